// ### ipcsig_pkg.sv
// Purpose: constants and types of the doorbell irq block
// Assumes: one clock sys_clk at 10 MHz, async active-low reset rst_b
// Notes:   byte offsets, one aligned 32-bit word per register
//
// Function
// - thirty-two sources, one pending/mask/status bit each
// - all unmasked sources ORed onto one interrupt output
// - set command writes ones into pending bits
// - clear command writes ones clear pending bits
// - enable sets, disable clears mask bits
// - mask register readable, resets to zero
// - pending register readable, resets to zero
// - output high while any source pending and unmasked
// - status reads pending AND mask, resets zero
// - masked source never drives output, still pending
// - two instances, identifiers 31 and 39
package ipcsig_pkg;

  localparam int unsigned IPCSIG_NSRC  = 32;
  localparam int unsigned IPCSIG_AW    = 8;
  localparam int unsigned IPCSIG_DW    = 32;
  localparam int unsigned IPCSIG_ERR_W = 2;

  // register byte offsets
  localparam logic [7:0] OFF_SET_CMD     = 8'h00;
  localparam logic [7:0] OFF_CLEAR_CMD   = 8'h04;
  localparam logic [7:0] OFF_PENDING     = 8'h08;
  localparam logic [7:0] OFF_ENABLE_CMD  = 8'h0C;
  localparam logic [7:0] OFF_DISABLE_CMD = 8'h10;
  localparam logic [7:0] OFF_MASK_STATE  = 8'h14;
  localparam logic [7:0] OFF_ACT_STATUS  = 8'h18;
  localparam logic [7:0] OFF_INSTANCE_ID = 8'h1C;
  localparam logic [7:0] OFF_ERR_STATUS  = 8'h20;
  localparam logic [7:0] OFF_ERR_MASK    = 8'h24;

  // access error field positions
  localparam int unsigned ERR_BAD_WRITE_BIT = 0;
  localparam int unsigned ERR_BAD_READ_BIT  = 1;

  // reset values
  localparam logic [31:0] RST_BANK     = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
  localparam logic [1:0]  RST_ERR      = 2'h0;
  localparam logic [31:0] ID_FIRST     = 32'h0000_001F;
  localparam logic [31:0] ID_SECOND    = 32'h0000_0027;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ipcsig_req_t;

endpackage

// ### ipcsig_bit_bank.sv
// Purpose: 32 bits each set and cleared by its own vector
// Assumes: set and clear vectors are one-cycle command pulses
// Notes:   set wins when a bit sees set and clear together
`timescale 1ns/1ps
module ipcsig_bit_bank
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [31:0] set_vec,
  input  wire logic [31:0] clr_vec,
  output logic      [31:0] bits
);

  genvar g;
  generate
    for (g = 0; g < ipcsig_pkg::IPCSIG_NSRC; g++)
    begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          bits[g] <= ipcsig_pkg::RST_BANK[g];
        else if (clk_en)
          bits[g] <= set_vec[g] | (bits[g] & ~clr_vec[g]);
      end
    end
  endgenerate

endmodule

// ### ipcsig_doorbell.sv
// Purpose: interprocessor doorbell interrupt block with register port
// Assumes: master keeps strobes one cycle, never both at once
// Notes:   read data valid only in the cycle after the read strobe
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module ipcsig_doorbell
#(
  parameter logic [31:0] INSTANCE_ID = ipcsig_pkg::ID_FIRST
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    clk_en,
  input  wire ipcsig_pkg::ipcsig_req_t reg_req,
  output logic                  [31:0] reg_rdata,
  output logic                         irq_out,
  output logic                         err_irq
);

  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] pend_set;
  logic [31:0] pend_clr;
  logic [31:0] mask_set;
  logic [31:0] mask_clr;
  logic [31:0] pending;
  logic [31:0] mask;
  logic [31:0] active;
  logic [31:0] next_rdata;
  logic        rd_mapped;
  logic        wr_mapped;
  logic [1:0]  err_status;
  logic [1:0]  err_mask;
  logic [1:0]  err_set;
  logic [1:0]  err_clr;
  logic [1:0]  next_err_status;

  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  // a frozen clock enable also drops any strobe of that cycle
  assign wr_ok = reg_req.wr & clk_en;
  assign rd_ok = reg_req.rd & clk_en;

  // command decode: zeros in the written word leave bits alone
  always_comb
  begin
    pend_set = 32'h0000_0000;
    pend_clr = 32'h0000_0000;
    mask_set = 32'h0000_0000;
    mask_clr = 32'h0000_0000;
    if (wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_SET_CMD))
      pend_set = reg_req.wdata;
    if (wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_CLEAR_CMD))
      pend_clr = reg_req.wdata;
    if (wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_ENABLE_CMD))
      mask_set = reg_req.wdata;
    if (wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_DISABLE_CMD))
      mask_clr = reg_req.wdata;
  end

  ipcsig_bit_bank u_pending
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .set_vec (pend_set),
    .clr_vec (pend_clr),
    .bits    (pending)
  );

  ipcsig_bit_bank u_mask
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .set_vec (mask_set),
    .clr_vec (mask_clr),
    .bits    (mask)
  );

  // masked sources drop out here and block nobody else
  assign active = pending & mask;

  // read mux; write-only offsets answer zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_mapped  = 1'b1;
    case (reg_req.addr)
      ipcsig_pkg::OFF_SET_CMD,
      ipcsig_pkg::OFF_CLEAR_CMD,
      ipcsig_pkg::OFF_ENABLE_CMD,
      ipcsig_pkg::OFF_DISABLE_CMD:
        next_rdata = 32'h0000_0000;
      ipcsig_pkg::OFF_PENDING:
        next_rdata = pending;
      ipcsig_pkg::OFF_MASK_STATE:
        next_rdata = mask;
      ipcsig_pkg::OFF_ACT_STATUS:
        next_rdata = active;
      ipcsig_pkg::OFF_INSTANCE_ID:
        next_rdata = INSTANCE_ID;
      ipcsig_pkg::OFF_ERR_STATUS:
        next_rdata = {30'h0, err_status};
      ipcsig_pkg::OFF_ERR_MASK:
        next_rdata = {30'h0, err_mask};
      default:
        rd_mapped = 1'b0;
    endcase
    if (!rd_ok)
      next_rdata = 32'h0000_0000;
  end

  // writes land only on command and error-control words
  always_comb
  begin
    case (reg_req.addr)
      ipcsig_pkg::OFF_SET_CMD,
      ipcsig_pkg::OFF_CLEAR_CMD,
      ipcsig_pkg::OFF_ENABLE_CMD,
      ipcsig_pkg::OFF_DISABLE_CMD,
      ipcsig_pkg::OFF_ERR_STATUS,
      ipcsig_pkg::OFF_ERR_MASK:
        wr_mapped = 1'b1;
      default:
        wr_mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    err_set = 2'h0;
    err_clr = 2'h0;
    err_set[ipcsig_pkg::ERR_BAD_WRITE_BIT] = wr_ok & ~wr_mapped;
    err_set[ipcsig_pkg::ERR_BAD_READ_BIT]  = rd_ok & ~rd_mapped;
    if (wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_ERR_STATUS))
      err_clr = reg_req.wdata[1:0];
    // a new error in the clearing cycle survives the clear
    next_err_status = err_set | (err_status & ~err_clr);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= ipcsig_pkg::RST_RDATA;
    else if (clk_en)
      reg_rdata <= next_rdata;
  end

  // one register stage: output lags the bits by one edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_out <= 1'b0;
    else if (clk_en)
      irq_out <= |active;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      err_status <= ipcsig_pkg::RST_ERR;
    else if (clk_en)
      err_status <= next_err_status;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      err_mask <= ipcsig_pkg::RST_ERR;
    else if (wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_ERR_MASK))
      err_mask <= reg_req.wdata[1:0];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      err_irq <= 1'b0;
    else if (clk_en)
      err_irq <= |(err_status & err_mask);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_set_write;
    wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_SET_CMD);
  endsequence

  sequence s_clear_write;
    wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_CLEAR_CMD);
  endsequence

  sequence s_enable_write;
    wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_ENABLE_CMD);
  endsequence

  sequence s_disable_write;
    wr_ok && addr_hit(reg_req.addr, ipcsig_pkg::OFF_DISABLE_CMD);
  endsequence

  sequence s_cmd_read;
    rd_ok && (addr_hit(reg_req.addr, ipcsig_pkg::OFF_SET_CMD)
              || addr_hit(reg_req.addr, ipcsig_pkg::OFF_CLEAR_CMD)
              || addr_hit(reg_req.addr, ipcsig_pkg::OFF_ENABLE_CMD)
              || addr_hit(reg_req.addr, ipcsig_pkg::OFF_DISABLE_CMD));
  endsequence

  a_set_ones_land:
    assert property (s_set_write |=>
      ((pending & $past(reg_req.wdata)) == $past(reg_req.wdata))
      && ((pending & ~$past(reg_req.wdata))
          == ($past(pending) & ~$past(reg_req.wdata))))
    else $error("set command did not set exactly the written bits");

  a_clear_ones_land:
    assert property (s_clear_write |=>
      ((pending & $past(reg_req.wdata)) == 32'h0000_0000)
      && ((pending & ~$past(reg_req.wdata))
          == ($past(pending) & ~$past(reg_req.wdata))))
    else $error("clear command did not clear exactly the written bits");

  a_mask_enable_bits:
    assert property (s_enable_write |=>
      (mask == ($past(mask) | $past(reg_req.wdata))))
    else $error("enable command gave the wrong mask");

  a_mask_disable_bits:
    assert property (s_disable_write |=>
      (mask == ($past(mask) & ~$past(reg_req.wdata))))
    else $error("disable command gave the wrong mask");

  a_mask_read_back:
    assert property ((rd_ok
      && addr_hit(reg_req.addr, ipcsig_pkg::OFF_MASK_STATE))
      |=> (reg_rdata == $past(mask)))
    else $error("mask read returned the wrong word");

  a_pending_read_back:
    assert property ((rd_ok
      && addr_hit(reg_req.addr, ipcsig_pkg::OFF_PENDING))
      |=> (reg_rdata == $past(pending)))
    else $error("pending read returned the wrong word");

  a_status_is_and:
    assert property ((rd_ok
      && addr_hit(reg_req.addr, ipcsig_pkg::OFF_ACT_STATUS))
      |=> (reg_rdata == ($past(pending) & $past(mask))))
    else $error("status read is not pending and mask");

  a_irq_tracks_active:
    assert property (clk_en |=> (irq_out == $past(|(pending & mask))))
    else $error("interrupt output does not follow active sources");

  a_set_raises_irq:
    assert property ((s_set_write ##0 ((reg_req.wdata & mask) != 0)
      ##1 clk_en) |=> irq_out)
    else $error("set of an unmasked source did not raise the output");

  a_masked_stays_quiet:
    assert property ((clk_en && (mask == 32'h0000_0000)
      && (pending != 32'h0000_0000)) |=> !irq_out)
    else $error("masked pending source drove the output");

  a_cmd_read_zero:
    assert property (s_cmd_read |=>
      (reg_rdata == 32'h0000_0000) && $stable(pending) && $stable(mask))
    else $error("command register read had data or a side effect");

  a_instance_id_read:
    assert property ((rd_ok
      && addr_hit(reg_req.addr, ipcsig_pkg::OFF_INSTANCE_ID))
      |=> (reg_rdata == INSTANCE_ID))
    else $error("instance identifier read wrong");

  a_rdata_one_cycle:
    assert property ((clk_en && !reg_req.rd) |=>
      (reg_rdata == 32'h0000_0000))
    else $error("read data stood outside its cycle");

  a_err_set_wins:
    assert property ((err_set != 2'h0) && clk_en |=>
      ((err_status & $past(err_set)) == $past(err_set)))
    else $error("access error event lost");

endmodule

// ### ipcsig_core_model.sv
// Purpose: far-side core model, clock gate and interrupt controller
// Assumes: software opens the clock gate before any register access
// Notes:   counts rising edges of the doorbell line
`timescale 1ns/1ps
module ipcsig_core_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_gate,
  input  wire logic       irq_in,
  output logic            clk_en,
  output logic      [7:0] irq_edges
);
  logic irq_q;
  // no power-up latency modelled, gate passes straight through
  assign clk_en = clk_gate;
  // controller is armed from reset, before the block is set up
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_q     <= 1'b0;
      irq_edges <= 8'h00;
    end
    else
    begin
      irq_q <= irq_in;
      if (irq_in && !irq_q)
        irq_edges <= irq_edges + 8'h01;
    end
  end
endmodule

// ### interprocessor_doorbell_irq_tb.sv
// Purpose: self-checking bench for the doorbell irq block
// Assumes: one access per task, idle cycle between accesses
// Notes:   integer model of pending, mask and error state
`timescale 1ns/1ps
module interprocessor_doorbell_irq_tb;
  logic                    sys_clk;
  logic                    rst_b;
  logic                    clk_gate;
  logic                    clk_en;
  ipcsig_pkg::ipcsig_req_t reg_req;
  logic             [31:0] reg_rdata;
  logic                    irq_out;
  logic                    err_irq;
  logic             [31:0] pend;
  logic             [31:0] mask;
  logic              [1:0] err;
  logic              [1:0] emask;
  logic              [7:0] irq_edges;
  int                      edges;
  logic              [7:0] ops [4] = '{8'h00, 8'h04, 8'h0C, 8'h10};
  int                      err_count;
  int                      cmp_count;
  int                      seed;
  int                      i;

  ipcsig_doorbell #(.INSTANCE_ID(ipcsig_pkg::ID_FIRST)) ipcsig_doorbell_i
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .reg_req   (reg_req),
    .reg_rdata (reg_rdata),
    .irq_out   (irq_out),
    .err_irq   (err_irq)
  );

  ipcsig_core_model ipcsig_core_model_i
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clk_gate  (clk_gate),
    .irq_in    (irq_out),
    .clk_en    (clk_en),
    .irq_edges (irq_edges)
  );

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic upd(input logic [7:0] ad, input logic [31:0] dt);
    case (ad)
      8'h00: pend = pend | dt;
      8'h04: pend = pend & ~dt;
      8'h0C: mask = mask | dt;
      8'h10: mask = mask & ~dt;
      8'h20: err = err & ~dt[1:0];
      8'h24: emask = dt[1:0];
      default: err[0] = 1'b1;
    endcase
  endtask

  // caller sits on a rising edge; irq levels trail the write by one edge
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    logic was_on;
    was_on = |(pend & mask);
    reg_req <= {ad, dt, 1'b1, 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    if (clk_gate)
      upd(ad, dt);
    // the controller sees one rising edge per off-to-on step
    if (!was_on && |(pend & mask))
      edges++;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, irq_out}, {31'h0, |(pend & mask)});
    chk({31'h0, err_irq}, {31'h0, |(err & emask)});
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] ad);
    logic [31:0] ex;
    case (ad)
      8'h08: ex = pend;
      8'h14: ex = mask;
      8'h18: ex = pend & mask;
      8'h1C: ex = ipcsig_pkg::ID_FIRST;
      8'h20: ex = {30'h0, err};
      8'h24: ex = {30'h0, emask};
      default: ex = 32'h0;
    endcase
    if (ad > 8'h24 || ad[1:0] != 2'h0)
      err[1] = 1'b1;
    reg_req <= {ad, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, ex);
    @(posedge sys_clk);
  endtask

  task automatic reset_all;
    rst_b <= 1'b0;
    pend = '0;
    mask = '0;
    err = '0;
    emask = '0;
    edges = 0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    complete_run();
  end

  initial
  begin
    seed = 32'h4A17;
    err_count = 0;
    cmp_count = 0;
    reg_req = '0;
    clk_gate = 1'b1;
    rst_b = 1'b0;
    @(posedge sys_clk);
    reset_all();
    rd(8'h08);
    rd(8'h14);
    rd(8'h18);
    $display("test reset values done");
    wr(8'h10, 32'hFFFFFFFF);
    wr(8'h00, 32'h80000001);
    rd(8'h08);
    wr(8'h0C, 32'h80000000);
    wr(8'h04, 32'h80000000);
    rd(8'h18);
    $display("test masked source done");
    for (i = 0; i < 60; i++)
    begin
      // sparse data so bits both gather and drain
      wr(ops[$unsigned($random(seed)) % 4],
         $random(seed) & $random(seed));
      rd(8'h08);
      rd(8'h14);
      rd(8'h18);
    end
    chk({24'h0, irq_edges}, {24'h0, edges[7:0]});
    $display("test random commands done");
    for (i = 0; i < 4; i++)
      rd(ops[i]);
    rd(8'h08);
    $display("test command reads done");
    clk_gate <= 1'b0;
    wr(8'h00, 32'hFFFFFFFF);
    clk_gate <= 1'b1;
    rd(8'h08);
    $display("test clock gate done");
    wr(8'h24, 32'h00000003);
    wr(8'h40, 32'h00000001);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h44);
    rd(8'h20);
    rd(8'h1C);
    wr(8'h20, 32'h00000003);
    rd(8'h08);
    $display("test access errors done");
    reset_all();
    chk({31'h0, irq_out}, 32'h0);
    rd(8'h08);
    rd(8'h14);
    $display("test second reset done");
    complete_run();
  end
endmodule
